// ### rtl/oht_regs.vh
// Register map, field positions, reset values and timing counts of the OTG timer block.
`ifndef OHT_REGS_VH
`define OHT_REGS_VH

// ----------------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------------
`define OHT_ADDR_CTRL 8'h00
`define OHT_ADDR_TIMEOUT 8'h04
`define OHT_ADDR_INT_STATUS 8'h08
`define OHT_ADDR_INT_CLEAR 8'h0C
`define OHT_ADDR_INT_MASK 8'h10

// ----------------------------------------------------------------------------
// Control and status register fields
// ----------------------------------------------------------------------------
`define OHT_CNT_HI 31
`define OHT_CNT_LO 16
`define OHT_BIT_TRACK_HOST 9
`define OHT_BIT_TRACK_PERIPH 8
`define OHT_BIT_I2C_EN 7
`define OHT_BIT_RESTART 6
`define OHT_BIT_ENABLE 5
`define OHT_BIT_MODE 4
`define OHT_SCALE_HI 3
`define OHT_SCALE_LO 2
`define OHT_BIT_HOSTSEL 0

// ----------------------------------------------------------------------------
// Interrupt status, clear and mask fields
// ----------------------------------------------------------------------------
`define OHT_INT_W 4
`define OHT_INT_TIMER 0
`define OHT_INT_FAILURE 2
`define OHT_INT_SUCCESS 3

// ----------------------------------------------------------------------------
// Reset values and encodings
// ----------------------------------------------------------------------------
`define OHT_RST_COUNT 16'h0000
`define OHT_RST_TIMEOUT 16'hFFFF
`define OHT_RST_INT 4'h0
`define OHT_MODE_MONOSHOT 1'b0
`define OHT_SCALE_10US 2'h0
`define OHT_SCALE_100US 2'h1
`define OHT_SCALE_1000US 2'h2

// ----------------------------------------------------------------------------
// Timing: tick periods in microseconds and their cycle counts at the clock rate
// ----------------------------------------------------------------------------
`define OHT_CLK_MHZ 17'h00064
`define OHT_TICK0_US 17'h0000A
`define OHT_TICK1_US 17'h00064
`define OHT_TICK2_US 17'h003E8
`define OHT_TICK0_CYC (`OHT_TICK0_US * `OHT_CLK_MHZ)
`define OHT_TICK1_CYC (`OHT_TICK1_US * `OHT_CLK_MHZ)
`define OHT_TICK2_CYC (`OHT_TICK2_US * `OHT_CLK_MHZ)

`endif

// ### rtl/oht_tick_gen.v
// Prescaler that makes the timer tick at the selected granularity.
`timescale 1ns/100ps
`include "oht_regs.vh"

module oht_tick_gen
#(
  parameter [16:0] TICK0_CYCLES = `OHT_TICK0_CYC,
  parameter [16:0] TICK1_CYCLES = `OHT_TICK1_CYC,
  parameter [16:0] TICK2_CYCLES = `OHT_TICK2_CYC
)
(
  input wire clk_i,
  input wire rst_i,
  input wire run_i,
  input wire restart_i,
  input wire [1:0] scale_i,
  output wire tick_o
);

  reg [16:0] presc;
  reg [16:0] limit;

  // Period of the selected scale; the reserved code never ticks.
  always @*
  begin
    case (scale_i)
      `OHT_SCALE_10US: limit = TICK0_CYCLES - 17'h00001;
      `OHT_SCALE_100US: limit = TICK1_CYCLES - 17'h00001;
      `OHT_SCALE_1000US: limit = TICK2_CYCLES - 17'h00001;
      default: limit = 17'h1FFFF;
    endcase
  end

  // A tick is one cycle at the last count of the period.
  assign tick_o = run_i & ~restart_i & (presc == limit) & (scale_i != 2'h3);

  // Prescaler counts only while running and starts over on restart.
  always @(posedge clk_i)
  begin
    if (rst_i || restart_i || !run_i || tick_o)
      presc <= 17'h00000;
    else if (presc < limit)
      presc <= presc + 17'h00001;
    else
      presc <= 17'h00000;
  end

endmodule

// ### rtl/oht_irq.v
// Sticky interrupt status with mask and one level interrupt output.
`timescale 1ns/100ps
`include "oht_regs.vh"

module oht_irq
(
  input wire clk_i,
  input wire rst_i,
  input wire [3:0] event_i,
  input wire read_clear_i,
  input wire [3:0] write_clear_i,
  input wire mask_we_i,
  input wire [3:0] mask_i,
  output reg [3:0] status_o,
  output reg [3:0] mask_o,
  output wire irq_o
);

  // Events set status bits; a set in the clearing cycle wins.
  always @(posedge clk_i)
  begin
    if (rst_i)
      status_o <= `OHT_RST_INT;
    else if (read_clear_i)
      status_o <= event_i;
    else
      status_o <= (status_o & ~write_clear_i) | event_i;
  end

  // Mask register, one bit per status bit.
  always @(posedge clk_i)
  begin
    if (rst_i)
      mask_o <= `OHT_RST_INT;
    else if (mask_we_i)
      mask_o <= mask_i;
  end

  // Interrupt level while any unmasked status bit is set.
  assign irq_o = |(status_o & mask_o);

endmodule

// ### rtl/oht_top.v
// Hnp_timer_control_reg and control block: timer, role-swap tracking, pad steering, Wishbone slave.
//
// Contract
// - Host-side tracking bit cleared on time-out/failure.
// - Peripheral-side tracking bit cleared on success/failure.
// - Hardware tracks negotiation, reports through interrupts.
// - Transparent mode: float pad, pull-up, reroute interrupt.
// - Restart bit write one resets timer count.
// - Enable starts timer; disabling restarts from zero.
// - Mode bit: zero monoshot, one free running.
// - Monoshot: interrupt at time-out, then auto-disable.
// - Free running: interrupt each time-out, reload, continue.
// - Scale: 10, 100, 1000 microseconds; 11 reserved.
// - Selection field zero enables peripheral operation.
// - Present count readable in bits 31:16.
// - Interrupt clear bit zero resets timer flag.
`timescale 1ns/100ps
`include "oht_regs.vh"

module oht_top
#(
  parameter [16:0] TICK1_CYCLES = `OHT_TICK1_CYC,
  parameter [16:0] TICK2_CYCLES = `OHT_TICK2_CYC
)
(
  input wire clk_i,
  input wire rst_i,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [7:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output reg [31:0] wb_dat_o,
  output reg wb_ack_o,
  output wire irq_o,
  input wire neg_success_i,
  input wire neg_failure_i,
  output reg track_role_swap_from_host_o,
  output reg track_role_swap_from_peripheral_o,
  output reg device_enable_o,
  input wire xcvr_drive_enable_n_i,
  input wire transceiver_irq_pin_n_i,
  input wire transceiver_drive_enable_pin_n_i,
  output reg transceiver_drive_enable_pin_n_o,
  output reg transceiver_drive_enable_pin_n_oe_o,
  output reg drive_enable_pullup_o,
  output reg xcvr_irq_n_o
);

  // --------------------------------------------------------------------------
  // Declarations
  // --------------------------------------------------------------------------
  reg ctl_track_host;
  reg ctl_track_periph;
  reg ctl_i2c;
  reg ctl_enable;
  reg ctl_mode;
  reg [1:0] ctl_scale;
  reg ctl_hostsel;
  reg [15:0] count;
  reg [15:0] timeout;
  reg next_track_host;
  reg next_track_periph;
  reg next_i2c;
  reg next_enable;
  reg next_mode;
  reg [1:0] next_scale;
  reg next_hostsel;
  reg [31:0] rd_value;
  wire req;
  wire wr_do;
  wire rd_do;
  wire sel_ctrl;
  wire sel_timeout;
  wire sel_status;
  wire sel_clear;
  wire sel_mask;
  wire [31:0] ctrl_word;
  wire [31:0] ctrl_merged;
  wire [31:0] timeout_merged;
  wire [31:0] mask_merged;
  wire restart_wr;
  wire tick;
  wire [15:0] count_inc;
  wire timer_evt;
  wire success_evt;
  wire failure_evt;
  wire [3:0] int_events;
  wire [3:0] int_status;
  wire [3:0] int_mask;

  // --------------------------------------------------------------------------
  // Helper functions
  // --------------------------------------------------------------------------

  // Replaces the byte lanes of a word that the byte selects enable.
  function [31:0] merge_lanes;
    input [31:0] old_word;
    input [31:0] new_word;
    input [3:0] sel;
    integer k;
    begin
      merge_lanes = old_word;
      for (k = 0; k < 4; k = k + 1)
      begin
        if (sel[k])
          merge_lanes[k*8 +: 8] = new_word[k*8 +: 8];
      end
    end
  endfunction

  // Tells whether a byte address hits a register offset.
  function hits;
    input [7:0] adr;
    input [7:0] offset;
    begin
      hits = (adr == offset);
    end
  endfunction

  // --------------------------------------------------------------------------
  // Wishbone slave handshake
  // --------------------------------------------------------------------------

  // A request is answered one cycle later; effects happen at the ack edge.
  assign req = wb_cyc_i & wb_stb_i;
  assign wr_do = req & wb_ack_o & wb_we_i;
  assign rd_do = req & wb_ack_o & ~wb_we_i;

  // Address decode for the mapped registers.
  assign sel_ctrl = hits(wb_adr_i, `OHT_ADDR_CTRL);
  assign sel_timeout = hits(wb_adr_i, `OHT_ADDR_TIMEOUT);
  assign sel_status = hits(wb_adr_i, `OHT_ADDR_INT_STATUS);
  assign sel_clear = hits(wb_adr_i, `OHT_ADDR_INT_CLEAR);
  assign sel_mask = hits(wb_adr_i, `OHT_ADDR_INT_MASK);

  // Ack rises one cycle after the request and drops after one cycle.
  always @(posedge clk_i)
  begin
    if (rst_i)
      wb_ack_o <= 1'b0;
    else
      wb_ack_o <= req & ~wb_ack_o;
  end

  // --------------------------------------------------------------------------
  // Read path
  // --------------------------------------------------------------------------

  // Control word as software sees it; restart and reserved bits read zero.
  assign ctrl_word = {count, 6'h00, ctl_track_host, ctl_track_periph, ctl_i2c, 1'b0,
                      ctl_enable, ctl_mode, ctl_scale, 1'b0, ctl_hostsel};

  // Read multiplexer; unmapped and write-only offsets read zero.
  always @*
  begin
    rd_value = 32'h00000000;
    if (sel_ctrl)
      rd_value = ctrl_word;
    else if (sel_timeout)
      rd_value = {16'h0000, timeout};
    else if (sel_status)
      rd_value = {28'h0000000, int_status};
    else if (sel_mask)
      rd_value = {28'h0000000, int_mask};
  end

  // Read data is captured with the ack so it stands while ack is high.
  always @(posedge clk_i)
  begin
    if (rst_i)
      wb_dat_o <= 32'h00000000;
    else if (req && !wb_ack_o)
      wb_dat_o <= rd_value;
  end

  // --------------------------------------------------------------------------
  // Control register
  // --------------------------------------------------------------------------
  assign ctrl_merged = merge_lanes(ctrl_word, wb_dat_i, wb_sel_i);
  assign restart_wr = wr_do & sel_ctrl & wb_sel_i[0] & wb_dat_i[`OHT_BIT_RESTART];

  // Software writes first; hardware clears on outcome then override them.
  always @*
  begin
    next_track_host = ctl_track_host;
    next_track_periph = ctl_track_periph;
    next_i2c = ctl_i2c;
    next_enable = ctl_enable;
    next_mode = ctl_mode;
    next_scale = ctl_scale;
    next_hostsel = ctl_hostsel;
    if (wr_do && sel_ctrl)
    begin
      next_track_host = ctrl_merged[`OHT_BIT_TRACK_HOST];
      next_track_periph = ctrl_merged[`OHT_BIT_TRACK_PERIPH];
      next_i2c = ctrl_merged[`OHT_BIT_I2C_EN];
      next_enable = ctrl_merged[`OHT_BIT_ENABLE];
      next_mode = ctrl_merged[`OHT_BIT_MODE];
      next_scale = ctrl_merged[`OHT_SCALE_HI:`OHT_SCALE_LO];
      next_hostsel = ctrl_merged[`OHT_BIT_HOSTSEL];
    end
    if (timer_evt && ctl_mode == `OHT_MODE_MONOSHOT)
      next_enable = 1'b0;
    if (timer_evt || failure_evt)
      next_track_host = 1'b0;
    if (success_evt || failure_evt)
      next_track_periph = 1'b0;
  end

  // Control flip-flops, all zero after reset.
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ctl_track_host <= 1'b0;
      ctl_track_periph <= 1'b0;
      ctl_i2c <= 1'b0;
      ctl_enable <= 1'b0;
      ctl_mode <= `OHT_MODE_MONOSHOT;
      ctl_scale <= `OHT_SCALE_10US;
      ctl_hostsel <= 1'b0;
    end
    else
    begin
      ctl_track_host <= next_track_host;
      ctl_track_periph <= next_track_periph;
      ctl_i2c <= next_i2c;
      ctl_enable <= next_enable;
      ctl_mode <= next_mode;
      ctl_scale <= next_scale;
      ctl_hostsel <= next_hostsel;
    end
  end

  // Time-out value register, low half-word only.
  assign timeout_merged = merge_lanes({16'h0000, timeout}, wb_dat_i, wb_sel_i);
  always @(posedge clk_i)
  begin
    if (rst_i)
      timeout <= `OHT_RST_TIMEOUT;
    else if (wr_do && sel_timeout)
      timeout <= timeout_merged[15:0];
  end

  // --------------------------------------------------------------------------
  // Timer
  // --------------------------------------------------------------------------

  // Tick source for the selected granularity.
  oht_tick_gen
  #(
    .TICK0_CYCLES(`OHT_TICK0_CYC),
    .TICK1_CYCLES(TICK1_CYCLES),
    .TICK2_CYCLES(TICK2_CYCLES)
  )
  u_tick
  (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .run_i(ctl_enable),
    .restart_i(restart_wr),
    .scale_i(ctl_scale),
    .tick_o(tick)
  );

  // Time-out is the tick on which the count would reach the time-out value.
  assign count_inc = count + 16'h0001;
  assign timer_evt = ctl_enable & tick & (count_inc == timeout);

  // Count clears when disabled or restarted and reloads at each time-out.
  always @(posedge clk_i)
  begin
    if (rst_i)
      count <= `OHT_RST_COUNT;
    else if (restart_wr || !ctl_enable)
      count <= `OHT_RST_COUNT;
    else if (timer_evt)
      count <= `OHT_RST_COUNT;
    else if (tick)
      count <= count_inc;
  end

  // --------------------------------------------------------------------------
  // Negotiation tracking and interrupts
  // --------------------------------------------------------------------------

  // Outcomes are reported only while a role swap is being tracked.
  assign success_evt = neg_success_i & (ctl_track_host | ctl_track_periph);
  assign failure_evt = neg_failure_i & (ctl_track_host | ctl_track_periph);
  assign int_events = {success_evt, failure_evt, 1'b0, timer_evt};
  assign mask_merged = merge_lanes({28'h0000000, int_mask}, wb_dat_i, wb_sel_i);

  // Sticky status, mask and interrupt line.
  oht_irq u_irq
  (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .event_i(int_events),
    .read_clear_i(rd_do & sel_status),
    .write_clear_i((wr_do & sel_clear & wb_sel_i[0]) ? wb_dat_i[3:0] : 4'h0),
    .mask_we_i(wr_do & sel_mask),
    .mask_i(mask_merged[3:0]),
    .status_o(int_status),
    .mask_o(int_mask),
    .irq_o(irq_o)
  );

  // Tracking state and port selection for the negotiation engine.
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      track_role_swap_from_host_o <= 1'b0;
      track_role_swap_from_peripheral_o <= 1'b0;
      device_enable_o <= 1'b1;
    end
    else
    begin
      track_role_swap_from_host_o <= next_track_host;
      track_role_swap_from_peripheral_o <= next_track_periph;
      device_enable_o <= ~next_hostsel;
    end
  end

  // --------------------------------------------------------------------------
  // Transceiver pad steering
  // --------------------------------------------------------------------------

  // Transparent mode floats the pad, pulls it up and takes the interrupt from it.
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      transceiver_drive_enable_pin_n_o <= 1'b1;
      transceiver_drive_enable_pin_n_oe_o <= 1'b1;
      drive_enable_pullup_o <= 1'b0;
      xcvr_irq_n_o <= 1'b1;
    end
    else
    begin
      transceiver_drive_enable_pin_n_o <= xcvr_drive_enable_n_i;
      transceiver_drive_enable_pin_n_oe_o <= ~ctl_i2c;
      drive_enable_pullup_o <= ctl_i2c;
      xcvr_irq_n_o <= ctl_i2c ? transceiver_drive_enable_pin_n_i
                              : transceiver_irq_pin_n_i;
    end
  end

endmodule

// ### dv/oht_checker.sv
// Concurrent checks on the ports of the OTG timer and role-swap block.
`timescale 1ns/100ps
module oht_checker
(
  input logic clk_i,
  input logic rst_i,
  input logic wb_cyc_i,
  input logic wb_stb_i,
  input logic wb_we_i,
  input logic [7:0] wb_adr_i,
  input logic [31:0] wb_dat_o,
  input logic wb_ack_o,
  input logic neg_success_i,
  input logic neg_failure_i,
  input logic track_role_swap_from_host_o,
  input logic track_role_swap_from_peripheral_o,
  input logic transceiver_irq_pin_n_i,
  input logic transceiver_drive_enable_pin_n_i,
  input logic transceiver_drive_enable_pin_n_oe_o,
  input logic drive_enable_pullup_o,
  input logic xcvr_irq_n_o,
  input logic xcvr_drive_enable_n_i,
  input logic transceiver_drive_enable_pin_n_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // A read answer is on the bus while the master still holds the address.
  wire rd_ack = wb_ack_o && !wb_we_i;
  // A request that is taken, then a single-cycle answer.
  sequence req_s;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence ans_s;
    wb_ack_o ##1 !wb_ack_o;
  endsequence
  bus_answer_a: assert property (req_s |=> ans_s)
    else $error("bus answer not a one-cycle ack");
  unmapped_zero_a: assert property (rd_ack && wb_adr_i > 8'h10 |-> wb_dat_o == 32'h0)
    else $error("unmapped read not zero");
  clear_reads_zero_a: assert property (
    rd_ack && wb_adr_i == 8'h0C |-> wb_dat_o == 32'h0)
    else $error("clear register read not zero");
  ctrl_reserved_a: assert property (
    rd_ack && wb_adr_i == 8'h00 |-> wb_dat_o[15:10] == 6'h00 && !wb_dat_o[6] && !wb_dat_o[1])
    else $error("reserved control bits read nonzero");
  pullup_oe_a: assert property (
    drive_enable_pullup_o != transceiver_drive_enable_pin_n_oe_o)
    else $error("pull-up and pad drive disagree");
  irq_route_a: assert property (!$past(rst_i) |-> xcvr_irq_n_o == (drive_enable_pullup_o ?
    $past(transceiver_drive_enable_pin_n_i) : $past(transceiver_irq_pin_n_i)))
    else $error("transceiver interrupt taken from wrong pin");
  pad_follow_a: assert property (!$past(rst_i) |->
    transceiver_drive_enable_pin_n_o == $past(xcvr_drive_enable_n_i))
    else $error("drive-enable pad not following the controller");
  host_track_a: assert property (
    track_role_swap_from_host_o && neg_failure_i |=> !track_role_swap_from_host_o)
    else $error("host-side tracking not cleared on failure");
  periph_track_a: assert property (track_role_swap_from_peripheral_o &&
    (neg_success_i || neg_failure_i) |=> !track_role_swap_from_peripheral_o)
    else $error("peripheral-side tracking not cleared");
endmodule

// ### dv/oht_xcvr_model.sv
// Model of the external transceiver's interrupt pin and drive-enable pad.
`timescale 1ns/100ps
module oht_xcvr_model
(
  input logic clk_i,
  input logic irq_req_i,
  input logic pad_o_i,
  input logic pad_oe_i,
  input logic pullup_i,
  output logic irq_pin_n_o,
  output logic pad_n_o
);
  logic flip = 1'b0;
  // A floating pad without pull-up shows a level that changes every cycle.
  always @(posedge clk_i)
  begin
    flip <= ~flip;
  end
  // In transparent mode the interrupt moves to the pad and the pin carries junk.
  assign irq_pin_n_o = pullup_i ? irq_req_i : ~irq_req_i;
  // Pad level: device drive, else with pull-up our pull-low on interrupt or the pull-up, else the toggling level.
  assign pad_n_o = pad_oe_i ? pad_o_i : pullup_i ? ~irq_req_i : flip;
endmodule

// ### dv/tb_top.sv
// Self-checking bench for the OTG timer and role-swap control block.
`timescale 1ns/100ps
module tb_top;
  localparam [16:0] T1 = 17'h00014;
  localparam [16:0] T2 = 17'h00028;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] dat = 32'h0;
  logic succ = 1'b0;
  logic fail = 1'b0;
  logic ireq = 1'b0;
  logic [3:0] sel = 4'hF;
  logic oen = 1'b1;
  logic [31:0] rdat, q;
  logic ack, irq, th, tp, dev, pin_n, pad_n, pad_o, pad_oe, pu, xirq;
  int n, to, s;
  int err_count = 0;
  int tests_run = 0;
  oht_top #(.TICK1_CYCLES(T1), .TICK2_CYCLES(T2)) u_oht_top (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .irq_o(irq), .neg_success_i(succ), .neg_failure_i(fail),
    .track_role_swap_from_host_o(th), .track_role_swap_from_peripheral_o(tp),
    .device_enable_o(dev), .xcvr_drive_enable_n_i(oen),
    .transceiver_irq_pin_n_i(pin_n), .transceiver_drive_enable_pin_n_i(pad_n),
    .transceiver_drive_enable_pin_n_o(pad_o),
    .transceiver_drive_enable_pin_n_oe_o(pad_oe), .drive_enable_pullup_o(pu),
    .xcvr_irq_n_o(xirq));
  oht_xcvr_model u_oht_xcvr_model (.clk_i(clk_i), .irq_req_i(ireq), .pad_o_i(pad_o),
    .pad_oe_i(pad_oe), .pullup_i(pu), .irq_pin_n_o(pin_n), .pad_n_o(pad_n));
  // Clock of 100 MHz.
  always #5 clk_i = ~clk_i;
  // Verdict and end of run.
  task automatic report_and_stop;
    $display("checks %0d errors %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // Comparison of a seen value against the expected one.
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // Tick length in cycles for a granularity code.
  function automatic int tk(int sc);
    return sc == 0 ? 1000 : sc == 1 ? int'(T1) : int'(T2);
  endfunction
  // One classic bus cycle, held until the ack edge.
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
    output logic [31:0] r, input logic [3:0] m = 4'hF);
    int c;
    c = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    sel <= m;
    adr <= a;
    dat <= d;
    @(posedge clk_i);
    while (ack !== 1'b1 && c < 20)
    begin
      @(posedge clk_i);
      c++;
    end
    r = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk_i);
    if (c >= 20)
    begin
      err_count++;
      report_and_stop();
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    wb(1'b1, a, d, r);
  endtask
  // Cycles until the interrupt line is seen high.
  task automatic wait_irq(output int c);
    c = 0;
    do
    begin
      @(posedge clk_i);
      c++;
    end
    while (irq !== 1'b1 && c < 4000);
    if (c >= 4000)
    begin
      err_count++;
      report_and_stop();
    end
  endtask
  // One-cycle negotiation outcome pulse.
  task automatic pulse(input logic ok);
    succ <= ok;
    fail <= !ok;
    @(posedge clk_i);
    succ <= 1'b0;
    fail <= 1'b0;
    @(posedge clk_i);
  endtask
  // Main sequence.
  initial
  begin
    void'($urandom(25));
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    wb(0, 8'h00, 0, q);
    chk("ctrl", q, 32'h0);
    wb(0, 8'h04, 0, q);
    chk("timeout", q, 32'h0000FFFF);
    wb(1, 8'h04, 32'h12345678, q, 4'h2);
    wb(0, 8'h04, 0, q);
    chk("byte lanes", q, 32'h000056FF);
    chk("dev", dev, 1);
    wb(0, 8'h14, 0, q);
    wb(0, 8'h0C, 0, q);
    wr(8'h00, 32'h1);
    chk("dev", dev, 0);
    for (s = 0; s < 3; s++)
    begin
      to = $urandom_range(1, 3);
      wr(8'h10, 32'hD);
      wr(8'h04, to);
      wr(8'h00, 32'h20 | (s << 2) | (s == 1 ? 32'h10 : 0));
      wait_irq(n);
      chk("period", n >= to * tk(s) - 2 && n <= to * tk(s) + 2, 1);
      wb(0, 8'h08, 0, q);
      chk("status", q, 32'h1);
      if (s == 1)
      begin
        wait_irq(n);
        chk("reload", n + 3 >= to * T1 - 2 && n + 3 <= to * T1 + 2, 1);
      end
      wb(0, 8'h00, 0, q);
      chk("enable", q[5], s == 1);
      wr(8'h00, 0);
      wb(0, 8'h08, 0, q);
    end
    wr(8'h00, 32'h2C);
    repeat (300) @(posedge clk_i);
    wb(0, 8'h00, 0, q);
    chk("scale3", q[31:16], 0);
    wr(8'h04, 10);
    wr(8'h00, 32'h34);
    repeat (100) @(posedge clk_i);
    wb(0, 8'h00, 0, q);
    chk("count", q[31:16] >= 4 && q[31:16] <= 5, 1);
    wr(8'h00, 32'h74);
    wb(0, 8'h00, 0, q);
    chk("restart", q[31:16], 0);
    wr(8'h00, 32'h14);
    wb(0, 8'h00, 0, q);
    chk("stopped", q[31:16], 0);
    wr(8'h00, 32'h34);
    wait_irq(n);
    chk("again", n >= 198 && n <= 202, 1);
    wr(8'h00, 32'h0);
    wr(8'h10, 32'h0);
    wr(8'h0C, 32'hF);
    wr(8'h04, 1);
    wr(8'h00, 32'h24);
    repeat (40) @(posedge clk_i);
    chk("masked", irq, 0);
    wr(8'h10, 32'hD);
    chk("unmasked", irq, 1);
    wr(8'h0C, 32'h1);
    chk("cleared", irq, 0);
    wr(8'h00, 32'h300);
    pulse(1);
    wb(0, 8'h08, 0, q);
    chk("success", {q[3:0], th, tp}, 6'h22);
    pulse(0);
    wb(0, 8'h08, 0, q);
    chk("failure", {q[3:0], th, tp}, 6'h10);
    pulse(0);
    wb(0, 8'h08, 0, q);
    chk("idle", q, 0);
    wr(8'h00, 32'h224);
    wait_irq(n);
    wb(0, 8'h00, 0, q);
    chk("timeout clears", q[9], 0);
    wb(0, 8'h08, 0, q);
    for (s = 0; s < 4; s++)
    begin
      wr(8'h00, (s & 2) << 6);
      ireq <= s[0];
      oen <= !s[0];
      repeat (3) @(posedge clk_i);
      chk("xirq", {xirq, pad_oe, pu, pad_o}, {!s[0], !s[1], s[1], !s[0]});
    end
    report_and_stop();
  end
endmodule
bind oht_top oht_checker u_chk (.*);
